// *** rtl/stpb_pkg.sv ***
// constants, reset values and ranges of the servo tuning parameter bank
//
// Notes on behaviour
// - proportional speed gain 0..8191, default 500, used
// - switch condition scales gain by rate, 10..500%
// - integral term from compensation value, 0..1023
// - feed forward 0..100% applied during speed control
// - command 10 restores defaults at next power-up
// - command 20 unlocks single protected parameter
// - command 22 unlocks nine protected parameters
// - command 406 enters forced output mode
// - command 400 returns to normal output control
// - input debounce time is value times 2 ms
package stpb_pkg;

	// ------------------------------------------------------------------
	// parameter addresses
	// ------------------------------------------------------------------
	localparam logic [15:0] ADDR_SPEED_PROP_GAIN  = 16'h0208;
	localparam logic [15:0] ADDR_SPEED_SWITCH     = 16'h020a;
	localparam logic [15:0] ADDR_SPEED_INTEGRAL   = 16'h020c;
	localparam logic [15:0] ADDR_SPEED_FEED_FWD   = 16'h020e;
	localparam logic [15:0] ADDR_SPECIAL_COMMAND  = 16'h0210;
	localparam logic [15:0] ADDR_DEBOUNCE         = 16'h0212;

	// ------------------------------------------------------------------
	// reset (factory) values
	// ------------------------------------------------------------------
	localparam logic [15:0] RST_SPEED_PROP_GAIN   = 16'h01f4;
	localparam logic [15:0] RST_SPEED_SWITCH      = 16'h0064;
	localparam logic [15:0] RST_SPEED_INTEGRAL    = 16'h0064;
	localparam logic [15:0] RST_SPEED_FEED_FWD    = 16'h0000;
	localparam logic [15:0] RST_SPECIAL_COMMAND   = 16'h0000;
	localparam logic [15:0] RST_DEBOUNCE          = 16'h0002;

	// ------------------------------------------------------------------
	// legal ranges, inclusive
	// ------------------------------------------------------------------
	localparam logic [15:0] MAX_SPEED_PROP_GAIN   = 16'h1fff;
	localparam logic [15:0] MIN_SPEED_SWITCH      = 16'h000a;
	localparam logic [15:0] MAX_SPEED_SWITCH      = 16'h01f4;
	localparam logic [15:0] MAX_SPEED_INTEGRAL    = 16'h03ff;
	localparam logic [15:0] MAX_SPEED_FEED_FWD    = 16'h0064;
	localparam logic [15:0] MAX_DEBOUNCE          = 16'h0014;
	localparam logic [15:0] MIN_ZERO              = 16'h0000;
	localparam logic [15:0] MAX_FULL              = 16'hffff;

	// ------------------------------------------------------------------
	// special command codes
	// ------------------------------------------------------------------
	localparam logic [15:0] CMD_FACTORY_RESTORE   = 16'h000a;
	localparam logic [15:0] CMD_UNLOCK_SINGLE     = 16'h0014;
	localparam logic [15:0] CMD_UNLOCK_RANGE      = 16'h0016;
	localparam logic [15:0] CMD_FORCE_OUT_ENTER   = 16'h0196;
	localparam logic [15:0] CMD_FORCE_OUT_LEAVE   = 16'h0190;

	// ------------------------------------------------------------------
	// scaling and timing
	// ------------------------------------------------------------------
	localparam int PERCENT_FULL         = 100;  // 100 % divisor
	localparam int CLK_KHZ              = 125000;
	localparam int DEBOUNCE_UNIT_MS     = 2;    // one count of filter time
	localparam int DEBOUNCE_UNIT_CYC    = DEBOUNCE_UNIT_MS * CLK_KHZ;
	localparam int DI_COUNT             = 8;    // digital input terminals

	// true when lo <= v <= hi
	function automatic logic in_range(input logic [15:0] v,
	                                  input logic [15:0] lo,
	                                  input logic [15:0] hi);
		in_range = (v >= lo) && (v <= hi);
	endfunction

endpackage

// *** rtl/stpb_dbn_if.sv ***
// link between the parameter bank and its input debounce filter
`timescale 1ns/1ns
`default_nettype none
interface stpb_dbn_if #(parameter int N = stpb_pkg::DI_COUNT);
	logic [4:0]   filt_units; // filter time in 2 ms units
	logic [N-1:0] di_raw;     // unsynchronised input pins
	logic [N-1:0] di_clean;   // filtered, registered inputs

	modport bank (output filt_units, output di_raw, input di_clean);
	modport filt (input filt_units, input di_raw, output di_clean);
endinterface
`default_nettype wire

// *** rtl/stpb_debounce.sv ***
// per-input contact bounce filter with a shared 2 ms time base
`timescale 1ns/1ns
`default_nettype none
module stpb_debounce #(
	parameter int N        = stpb_pkg::DI_COUNT,
	parameter int UNIT_CYC = stpb_pkg::DEBOUNCE_UNIT_CYC
) (
	input  wire logic core_clk,
	input  wire logic rst_b,
	stpb_dbn_if.filt  dbn
);
	import stpb_pkg::*;

	localparam int TW = $clog2(UNIT_CYC);
	localparam logic [TW-1:0] UNIT_LAST = TW'(UNIT_CYC - 1);

	// ------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [N-1:0]      s1;     // first sync stage, read only by s2
		logic [N-1:0]      s2;     // second sync stage
		logic [N-1:0]      stable; // accepted level
		logic [N-1:0][4:0] cnt;    // units the new level has held
		logic [TW-1:0]     pre;    // cycle prescaler
		logic              tick;   // one pulse per unit
	} stpb_dbn_state_type;

	stpb_dbn_state_type st_r;
	stpb_dbn_state_type st_nxt;

	assign dbn.di_clean = st_r.stable;

	// ------------------------------------------------------------------
	// next state
	// ------------------------------------------------------------------
	// a level is accepted only after it has held for filt_units whole
	// units; the first unit may be short by up to one tick period
	always_comb begin
		st_nxt      = st_r;
		st_nxt.s1   = dbn.di_raw;
		st_nxt.s2   = st_r.s1;
		st_nxt.tick = 1'b0;
		if (st_r.pre == UNIT_LAST) begin
			st_nxt.pre  = '0;
			st_nxt.tick = 1'b1;
		end else begin
			st_nxt.pre = st_r.pre + TW'(1);
		end
		for (int i = 0; i < N; i++) begin
			if (st_r.s2[i] == st_r.stable[i]) begin
				// bounce back to old level restarts the filter
				st_nxt.cnt[i] = 5'h00;
			end else if (dbn.filt_units == 5'h00) begin
				// zero filter time passes the level straight on
				st_nxt.stable[i] = st_r.s2[i];
				st_nxt.cnt[i]    = 5'h00;
			end else if (st_r.tick) begin
				if (st_r.cnt[i] + 5'h01 >= dbn.filt_units) begin
					st_nxt.stable[i] = st_r.s2[i];
					st_nxt.cnt[i]    = 5'h00;
				end else begin
					st_nxt.cnt[i] = st_r.cnt[i] + 5'h01;
				end
			end
		end
	end

	// ------------------------------------------------------------------
	// registers
	// ------------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

endmodule
`default_nettype wire

// *** rtl/stpb_bank.sv ***
// servo speed loop tuning parameter bank with special command word
`timescale 1ns/1ns
`default_nettype none
module stpb_bank #(
	parameter int DEBOUNCE_UNIT_CYCLES = stpb_pkg::DEBOUNCE_UNIT_CYC
) (
	input  wire logic                     core_clk,
	input  wire logic                     rst_b,
	input  wire logic                     par_wr_en,
	input  wire logic                     par_rd_en,
	input  wire logic [15:0]              par_addr,
	input  wire logic [15:0]              par_wr_data,
	output logic      [15:0]              par_rd_data,
	output logic                          par_ack,
	output logic                          par_err,
	input  wire logic                     gain_switch_cond,
	input  wire logic                     speed_ctrl_active,
	output logic      [15:0]              speed_kp_eff,
	output logic      [15:0]              speed_ki,
	output logic      [15:0]              speed_ff_gain,
	output logic                          factory_restore_req,
	output logic                          protected_single_unlock,
	output logic                          protected_range_unlock,
	output logic                          forced_output_mode,
	input  wire logic [stpb_pkg::DI_COUNT-1:0] di_pin,
	output logic      [stpb_pkg::DI_COUNT-1:0] di_filtered
);
	import stpb_pkg::*;

	// ------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------
	typedef struct packed {
		// stored parameters, each kept as a full 16-bit word so a
		// read returns exactly the value that was accepted
		logic [15:0] prop_gain; // speed_proportional_gain
		logic [15:0] sw_rate;   // speed_gain_switch_rate
		logic [15:0] integ;     // speed_integral_comp
		logic [15:0] fwd_gain;  // speed_feed_forward_gain
		logic [15:0] cmd;       // special_command_word
		logic [15:0] dbn_time;  // input_debounce_time
		// side effects of the command word
		logic        unl1;    // single protected parameter open
		logic        unl9;    // protected range open
		logic        forced;  // forced digital output mode
		logic [15:0] rd;      // read data
		logic        ack;     // access answered
		logic        err;     // access refused
		logic [15:0] kp_eff;  // gain after switching
		logic [15:0] ki;      // integral term
		logic [15:0] ff;      // applied feed forward
	} stpb_state_type;

	stpb_state_type st_r;
	stpb_state_type st_nxt;

	localparam stpb_state_type ST_RESET = '{
		prop_gain: RST_SPEED_PROP_GAIN, sw_rate: RST_SPEED_SWITCH,
		integ: RST_SPEED_INTEGRAL,  fwd_gain: RST_SPEED_FEED_FWD,
		cmd: RST_SPECIAL_COMMAND, dbn_time: RST_DEBOUNCE,
		unl1: 1'b0, unl9: 1'b0, forced: 1'b0,
		rd: 16'h0000, ack: 1'b0, err: 1'b0,
		kp_eff: RST_SPEED_PROP_GAIN, ki: RST_SPEED_INTEGRAL,
		ff: 16'h0000
	};

	logic [31:0] kp_scaled; // gain times rate, then over 100

	// ------------------------------------------------------------------
	// debounce filter
	// ------------------------------------------------------------------
	stpb_dbn_if #(.N(DI_COUNT)) dbn ();

	// five bits suffice: filter times above 20 are refused on write
	assign dbn.filt_units = st_r.dbn_time[4:0];
	assign dbn.di_raw     = di_pin;
	assign di_filtered    = dbn.di_clean;

	stpb_debounce #(
		.N        (DI_COUNT),
		.UNIT_CYC (DEBOUNCE_UNIT_CYCLES)
	) u_debounce (
		.core_clk (core_clk),
		.rst_b    (rst_b),
		.dbn      (dbn.filt)
	);

	// ------------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------------
	assign par_rd_data             = st_r.rd;
	assign par_ack                 = st_r.ack;
	assign par_err                 = st_r.err;
	assign speed_kp_eff            = st_r.kp_eff;
	assign speed_ki                = st_r.ki;
	assign speed_ff_gain           = st_r.ff;
	assign protected_single_unlock = st_r.unl1;
	assign protected_range_unlock  = st_r.unl9;
	assign forced_output_mode      = st_r.forced;
	// the bank itself holds no non-volatile copy: this level tells the
	// power-up loader to store factory values before the next start
	assign factory_restore_req = (st_r.cmd == CMD_FACTORY_RESTORE);

	// ------------------------------------------------------------------
	// next state
	// ------------------------------------------------------------------
	always_comb begin
		st_nxt     = st_r;
		st_nxt.ack = 1'b0;
		st_nxt.err = 1'b0;
		// worst case 8191 * 500 / 100 still fits in 16 bits
		kp_scaled  = 32'(st_r.prop_gain) * 32'(st_r.sw_rate) /
		             32'(PERCENT_FULL);

		// loop terms are registered so they change one cycle after
		// their inputs; the divide is by a constant only
		if (gain_switch_cond) begin
			st_nxt.kp_eff = kp_scaled[15:0];
		end else begin
			st_nxt.kp_eff = st_r.prop_gain;
		end
		st_nxt.ki = st_r.integ;
		st_nxt.ff = speed_ctrl_active ? st_r.fwd_gain : 16'h0000;

		if (par_wr_en) begin
			// writes win over a read in the same cycle
			st_nxt.ack = 1'b1;
			if (par_addr == ADDR_SPEED_PROP_GAIN) begin
				if (in_range(par_wr_data, MIN_ZERO,
				             MAX_SPEED_PROP_GAIN)) begin
					st_nxt.prop_gain = par_wr_data;
				end else begin
					st_nxt.err = 1'b1;
				end
			end else if (par_addr == ADDR_SPEED_SWITCH) begin
				if (in_range(par_wr_data, MIN_SPEED_SWITCH,
				             MAX_SPEED_SWITCH)) begin
					st_nxt.sw_rate = par_wr_data;
				end else begin
					st_nxt.err = 1'b1;
				end
			end else if (par_addr == ADDR_SPEED_INTEGRAL) begin
				if (in_range(par_wr_data, MIN_ZERO,
				             MAX_SPEED_INTEGRAL)) begin
					st_nxt.integ = par_wr_data;
				end else begin
					st_nxt.err = 1'b1;
				end
			end else if (par_addr == ADDR_SPEED_FEED_FWD) begin
				if (in_range(par_wr_data, MIN_ZERO,
				             MAX_SPEED_FEED_FWD)) begin
					st_nxt.fwd_gain = par_wr_data;
				end else begin
					st_nxt.err = 1'b1;
				end
			end else if (par_addr == ADDR_SPECIAL_COMMAND) begin
				// full 16-bit range is legal; codes act on write
				st_nxt.cmd = par_wr_data;
				if (par_wr_data == CMD_UNLOCK_SINGLE) begin
					st_nxt.unl1 = 1'b1;
				end else if (par_wr_data == CMD_UNLOCK_RANGE) begin
					st_nxt.unl9 = 1'b1;
				end else if (par_wr_data == CMD_FORCE_OUT_ENTER) begin
					st_nxt.forced = 1'b1;
				end else if (par_wr_data == CMD_FORCE_OUT_LEAVE) begin
					st_nxt.forced = 1'b0;
				end else begin
					// any other code is only stored; the unlocks stay
					// open until the next power-up
					st_nxt.forced = st_r.forced;
				end
			end else if (par_addr == ADDR_DEBOUNCE) begin
				if (in_range(par_wr_data, MIN_ZERO,
				             MAX_DEBOUNCE)) begin
					// the filter uses the new time from the next cycle on
					st_nxt.dbn_time = par_wr_data;
				end else begin
					st_nxt.err = 1'b1;
				end
			end else begin
				// unmapped address: nothing stored
				st_nxt.err = 1'b1;
			end
		end else if (par_rd_en) begin
			// a read never changes a parameter; the data register
			// keeps the word until the next read replaces it
			st_nxt.ack = 1'b1;
			if (par_addr == ADDR_SPEED_PROP_GAIN) begin
				st_nxt.rd = st_r.prop_gain;
			end else if (par_addr == ADDR_SPEED_SWITCH) begin
				st_nxt.rd = st_r.sw_rate;
			end else if (par_addr == ADDR_SPEED_INTEGRAL) begin
				st_nxt.rd = st_r.integ;
			end else if (par_addr == ADDR_SPEED_FEED_FWD) begin
				st_nxt.rd = st_r.fwd_gain;
			end else if (par_addr == ADDR_SPECIAL_COMMAND) begin
				// the last code written reads back, whatever it did
				st_nxt.rd = st_r.cmd;
			end else if (par_addr == ADDR_DEBOUNCE) begin
				st_nxt.rd = st_r.dbn_time;
			end else begin
				st_nxt.rd  = 16'h0000;
				st_nxt.err = 1'b1;
			end
		end
	end

	// ------------------------------------------------------------------
	// registers
	// ------------------------------------------------------------------
	// reset stands for power-up: every parameter takes its factory value
	// and the unlocks and forced mode close again; a restore code left
	// in the command word is cleared with them
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			st_r <= ST_RESET;
		end else begin
			st_r <= st_nxt;
		end
	end

endmodule
`default_nettype wire

// *** test/stpb_host_model.sv ***
// host model: keypad or serial master issuing parameter accesses
`timescale 1ns/1ns
`default_nettype none
module stpb_host_model (
	input  wire logic        core_clk,
	output logic             par_wr_en,
	output logic             par_rd_en,
	output logic [15:0]      par_addr,
	output logic [15:0]      par_wr_data,
	input  wire logic [15:0] par_rd_data,
	input  wire logic        par_ack,
	input  wire logic        par_err
);
	import stpb_pkg::*;
	logic servo_off = 1'b1; // drive state confirmed before a restore code

	// ------------------------------------------------------------------
	// idle levels at time zero
	// ------------------------------------------------------------------
	initial begin
		par_wr_en = 1'b0;
		par_rd_en = 1'b0;
		par_addr = 16'h0000;
		par_wr_data = 16'h0000;
	end

	// one access: drive after a falling edge, take the answer one cycle on
	task automatic access(input logic wr, input logic [15:0] a,
		input logic [15:0] d, output logic [15:0] q, output logic k,
		output logic f);
		@(negedge core_clk);
		// restore code only goes out while the drive is off
		par_wr_en = wr && (servo_off || d != CMD_FACTORY_RESTORE);
		par_rd_en = !wr;
		par_addr = a;
		par_wr_data = d;
		@(negedge core_clk);
		q = par_rd_data;
		k = par_ack;
		f = par_err;
		// released lines show no stale value
		par_wr_en = 1'b0;
		par_rd_en = 1'b0;
		par_addr = ~a;
		par_wr_data = ~d;
	endtask
endmodule
`default_nettype wire

// *** test/stpb_bank_monitor.sv ***
// assertion checker watching the parameter bank top ports
`timescale 1ns/1ns
`default_nettype none
module stpb_bank_monitor (
	input wire logic        core_clk,
	input wire logic        rst_b,
	input wire logic        par_wr_en,
	input wire logic        par_rd_en,
	input wire logic [15:0] par_addr,
	input wire logic [15:0] par_wr_data,
	input wire logic        par_ack,
	input wire logic        par_err,
	input wire logic        speed_ctrl_active,
	input wire logic [15:0] speed_ki,
	input wire logic [15:0] speed_ff_gain,
	input wire logic        factory_restore_req,
	input wire logic        protected_single_unlock,
	input wire logic        protected_range_unlock,
	input wire logic        forced_output_mode
);
	import stpb_pkg::*;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	logic wr_cmd; // write aimed at the command word
	assign wr_cmd = par_wr_en && par_addr == ADDR_SPECIAL_COMMAND;

	// ------------------------------------------------------------------
	// request port
	// ------------------------------------------------------------------
	chk_ack_follows_req:
	assert property ((par_wr_en || par_rd_en) |=> par_ack)
		else $error("request unanswered");
	chk_no_idle_ack:
	assert property (!(par_wr_en || par_rd_en) |=> !par_ack && !par_err)
		else $error("answer without request");
	chk_err_debounce_high:
	assert property (par_wr_en && par_addr == ADDR_DEBOUNCE &&
		par_wr_data > 16'h0014 |=> par_err)
		else $error("filter time over range kept");
	chk_err_switch_range:
	assert property (par_wr_en && par_addr == ADDR_SPEED_SWITCH &&
		(par_wr_data < 16'h000a || par_wr_data > 16'h01f4) |=> par_err)
		else $error("switch rate out of range kept");
	chk_integral_accepted:
	assert property (par_wr_en && par_addr == ADDR_SPEED_INTEGRAL &&
		par_wr_data <= 16'h03ff |=> par_ack && !par_err)
		else $error("legal integral refused");

	// ------------------------------------------------------------------
	// command word effects and loop outputs
	// ------------------------------------------------------------------
	chk_restore_flag_set:
	assert property (wr_cmd && par_wr_data == 16'h000a |=>
		factory_restore_req)
		else $error("restore not flagged");
	chk_single_unlock_set:
	assert property (wr_cmd && par_wr_data == 16'h0014 |=>
		protected_single_unlock [*2])
		else $error("single unlock missing");
	chk_range_unlock_set:
	assert property (wr_cmd && par_wr_data == 16'h0016 |=>
		protected_range_unlock)
		else $error("range unlock missing");
	chk_forced_enter:
	assert property (wr_cmd && par_wr_data == 16'h0196 |=>
		forced_output_mode)
		else $error("forced mode not entered");
	chk_forced_leave:
	assert property (wr_cmd && par_wr_data == 16'h0190 |=>
		!forced_output_mode)
		else $error("forced mode not left");
	chk_ff_gated_off:
	assert property (!speed_ctrl_active |=> speed_ff_gain == 16'h0000)
		else $error("feed forward outside speed control");
	chk_ki_in_range:
	assert property (speed_ki <= 16'h03ff)
		else $error("integral term over range");

	cover property (wr_cmd && par_wr_data == 16'h0196);
	cover property (par_ack && par_err);
	cover property (speed_ctrl_active ##1 speed_ff_gain != 16'h0000);
endmodule
bind stpb_bank stpb_bank_monitor mon_u (.core_clk(core_clk), .rst_b(rst_b),
	.par_wr_en(par_wr_en), .par_rd_en(par_rd_en), .par_addr(par_addr),
	.par_wr_data(par_wr_data), .par_ack(par_ack), .par_err(par_err),
	.speed_ctrl_active(speed_ctrl_active), .speed_ki(speed_ki),
	.speed_ff_gain(speed_ff_gain), .factory_restore_req(factory_restore_req),
	.protected_single_unlock(protected_single_unlock),
	.protected_range_unlock(protected_range_unlock),
	.forced_output_mode(forced_output_mode));
`default_nettype wire

// *** test/servo_tuning_parameter_bank_bench.sv ***
// self-checking bench of the tuning parameter bank
`timescale 1ns/1ns
`default_nettype none
module servo_tuning_parameter_bank_bench;
	import stpb_pkg::*;
	localparam int UNIT = 8; // shortened 2 ms tick keeps the run brief
	logic        core_clk = 1'b0;
	logic        rst_b = 1'b0;
	logic        gsw = 1'b0;  // gain switch condition
	logic        sca = 1'b0;  // speed control active
	logic [7:0]  di_pin = 8'h00;
	logic        wr_en, rd_en, ack, err, restore, unl_s, unl_r, forced;
	logic [15:0] addr, wdata, rdata, kp, ki, ff;
	logic [7:0]  di_filt;
	int          err_total = 0;
	int          cmp_count = 0;
	// command codes in the order sent, and the expected flags
	// {restore, single unlock, range unlock, forced} after each
	logic [15:0] cmds [5] = '{16'h000a, 16'h0014, 16'h0016,
	                          16'h0196, 16'h0190};
	logic [15:0] flags [5] = '{16'h0008, 16'h0004, 16'h0006,
	                           16'h0007, 16'h0006};
	logic [15:0] cmd_flags; // command word effects, one bit each
	assign cmd_flags = {12'h000, restore, unl_s, unl_r, forced};

	always #4 core_clk = ~core_clk;

	stpb_bank #(.DEBOUNCE_UNIT_CYCLES(UNIT)) dut_u (.core_clk(core_clk),
		.rst_b(rst_b), .par_wr_en(wr_en), .par_rd_en(rd_en),
		.par_addr(addr), .par_wr_data(wdata), .par_rd_data(rdata),
		.par_ack(ack), .par_err(err), .gain_switch_cond(gsw),
		.speed_ctrl_active(sca), .speed_kp_eff(kp), .speed_ki(ki),
		.speed_ff_gain(ff), .factory_restore_req(restore),
		.protected_single_unlock(unl_s), .protected_range_unlock(unl_r),
		.forced_output_mode(forced), .di_pin(di_pin), .di_filtered(di_filt));
	stpb_host_model host_u (.core_clk(core_clk), .par_wr_en(wr_en),
		.par_rd_en(rd_en), .par_addr(addr), .par_wr_data(wdata),
		.par_rd_data(rdata), .par_ack(ack), .par_err(err));

	// ------------------------------------------------------------------
	// compare, access and closing tasks
	// ------------------------------------------------------------------
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_total++;
			$display("BAD t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// one access, then the answer flags and, for reads, the data
	task automatic acc(input logic w, input logic [15:0] a,
		input logic [15:0] d, input logic [15:0] x, input logic e);
		logic [15:0] q;
		logic        k, f;
		host_u.access(w, a, d, q, k, f);
		chk({15'h0000, k}, 16'h0001);
		chk({15'h0000, f}, {15'h0000, e});
		if (!w) chk(q, x);
	endtask
	// read with expected data and refusal flag
	task automatic rd(input logic [15:0] a, input logic [15:0] x,
		input logic e);
		acc(1'b0, a, 16'h0000, x, e);
	endtask
	// write with expected refusal flag
	task automatic wr(input logic [15:0] a, input logic [15:0] d,
		input logic e);
		acc(1'b1, a, d, 16'h0000, e);
	endtask
	task automatic wait_cyc(input int n);
		repeat (n) @(negedge core_clk);
	endtask
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// watchdog: the tests need well under 1000 cycles
	initial begin
		#40000;
		err_total++;
		tally_and_finish();
	end

	// ------------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------------
	initial begin
		wait_cyc(20);
		rst_b = 1'b1;
		rd(ADDR_SPEED_PROP_GAIN, 16'h01f4, 1'b0);
		rd(ADDR_SPEED_SWITCH, 16'h0064, 1'b0);
		rd(ADDR_SPEED_INTEGRAL, 16'h0064, 1'b0);
		rd(ADDR_SPEED_FEED_FWD, 16'h0000, 1'b0);
		rd(ADDR_SPECIAL_COMMAND, 16'h0000, 1'b0);
		rd(ADDR_DEBOUNCE, 16'h0002, 1'b0);
		rd(16'h0214, 16'h0000, 1'b1);
		chk(kp, 16'h01f4);
		chk(ki, 16'h0064);
		// range edges: one past each upper end and one below the switch rate's lower end refused, the end itself kept
		wr(ADDR_SPEED_PROP_GAIN, 16'h2000, 1'b1);
		wr(ADDR_SPEED_PROP_GAIN, 16'h1fff, 1'b0);
		wr(ADDR_SPEED_SWITCH, 16'h0009, 1'b1);
		wr(ADDR_SPEED_SWITCH, 16'h01f5, 1'b1);
		wr(ADDR_SPEED_SWITCH, 16'h01f4, 1'b0);
		rd(ADDR_SPEED_SWITCH, 16'h01f4, 1'b0);
		gsw = 1'b1;
		wait_cyc(2);
		chk(kp, 16'h9ffb);
		wr(ADDR_SPEED_SWITCH, 16'h000a, 1'b0);
		wait_cyc(2);
		chk(kp, 16'h0333);
		gsw = 1'b0;
		wait_cyc(2);
		chk(kp, 16'h1fff);
		wr(ADDR_SPEED_INTEGRAL, 16'h0400, 1'b1);
		wr(ADDR_SPEED_INTEGRAL, 16'h03ff, 1'b0);
		wr(ADDR_SPEED_FEED_FWD, 16'h0065, 1'b1);
		wr(ADDR_SPEED_FEED_FWD, 16'h0064, 1'b0);
		wait_cyc(2);
		chk(ki, 16'h03ff);
		chk(ff, 16'h0000);
		sca = 1'b1;
		wait_cyc(2);
		chk(ff, 16'h0064);
		sca = 1'b0;
		wr(16'h0206, 16'h0001, 1'b1);
		// every command code, flags seen in the answer cycle
		foreach (cmds[i]) begin
			wr(ADDR_SPECIAL_COMMAND, cmds[i], 1'b0);
			chk(cmd_flags, flags[i]);
		end
		rd(ADDR_SPECIAL_COMMAND, 16'h0190, 1'b0);
		// a short bounce is swallowed, a steady level passes in time
		di_pin = 8'h01;
		wait_cyc(3);
		di_pin = 8'h00;
		wait_cyc(30);
		chk({8'h00, di_filt}, 16'h0000);
		di_pin = 8'h01;
		wait_cyc(UNIT);
		chk({8'h00, di_filt}, 16'h0000);
		wait_cyc(2 * UNIT);
		chk({8'h00, di_filt}, 16'h0001);
		wr(ADDR_DEBOUNCE, 16'h0015, 1'b1);
		wr(ADDR_DEBOUNCE, 16'h0000, 1'b0);
		di_pin = 8'h81;
		wait_cyc(8);
		chk({8'h00, di_filt}, 16'h0081);
		// a second power-up brings back factory values and closes locks
		rst_b = 1'b0;
		wait_cyc(2);
		rst_b = 1'b1;
		chk(cmd_flags, 16'h0000);
		rd(ADDR_SPEED_PROP_GAIN, 16'h01f4, 1'b0);
		rd(ADDR_DEBOUNCE, 16'h0002, 1'b0);
		tally_and_finish();
	end
endmodule
`default_nettype wire
